// ==== hw/pll_defs.svh ====
// Register map, field positions, reset values and timing counts for the lock-window block
// How it works
// - Two-bit timer speed field picks lock clock rate, 00 fastest, 11 slowest.
// - Three-bit divide code 0..7 gives 0.5 to 64 lock clock periods.
// - Window width spans the speed and divide table, short to long.
// - Window opens on whichever detector edge arrives first.
// - Cycle-slip guard boosts detector gain while unlocked and phase error passes chosen threshold.
// - Pump down gain sits at bits 6:0, up gain at bits 13:7.
// - Gain code 50 means 1 mA; current is linear in the code.
// - Bit 21 adds offset to up pump, bit 22 to down pump.
// - Offset magnitude bits 20:14, 0 to 635 uA in 5 uA steps.
// - Oscillator stays in its fundamental band; divider and doubler act after it.
// - One global enable bit gates all lock detection.
// - Window-source bit picks the timer window over the fixed one-shot window.
// - Lock rises after programmed run of in-window arrivals, drops on one miss.
// - Lock flag reads as bit 1 of the status register.
`ifndef PLL_DEFS_SVH
`define PLL_DEFS_SVH

// ************************************************************
// Register offsets (plain port, printed indices)
// ************************************************************
`define PLL_ADDR_W 5
`define PLL_OFS_LOCK_WINDOW_CONFIG 5'h07
`define PLL_OFS_PUMP_GAIN_OFFSET 5'h09
`define PLL_OFS_DETECTOR_FEATURES 5'h0b
`define PLL_OFS_OUTPUT_TUNING 5'h0d
`define PLL_OFS_LOCK_STATUS 5'h12

// ************************************************************
// Field positions
// ************************************************************
`define PLL_LW_WINCNT 2:0
`define PLL_LW_ENABLE 3
`define PLL_LW_DIGITAL 6
`define PLL_LW_DIVIDE 9:7
`define PLL_LW_SPEED 11:10
`define PLL_PG_DOWN 6:0
`define PLL_PG_UP 13:7
`define PLL_PG_OFS_MAG 20:14
`define PLL_PG_OFS_UP 21
`define PLL_PG_OFS_DOWN 22
`define PLL_DF_CSP 8:7
`define PLL_OT_DIVIDER 5:0
`define PLL_OT_DOUBLER 8
`define PLL_ST_LOCKED 1
`define PLL_ST_WINDOW 0

// ************************************************************
// Reset values
// ************************************************************
`define PLL_RST_LOCK_WINDOW_CONFIG 24'h000000
`define PLL_RST_PUMP_GAIN_OFFSET 24'h000000
`define PLL_RST_DETECTOR_FEATURES 24'h000000
`define PLL_RST_OUTPUT_TUNING 24'h000000

// ************************************************************
// Timing and scaling
// ************************************************************
`define PLL_CLK_MHZ 40
`define PLL_ANALOG_WIN_NS 10
`define PLL_ANALOG_RAW ((`PLL_ANALOG_WIN_NS * `PLL_CLK_MHZ) / 1000)
`define PLL_ANALOG_WIN_CYC ((`PLL_ANALOG_RAW < 1) ? 1 : `PLL_ANALOG_RAW)
`define PLL_LOCK_BASE 32
`define PLL_CSP_BASE 2
`define PLL_GAIN_UA_PER_CODE 20
`define PLL_OFS_UA_PER_CODE 5
`define PLL_DIV_MIN 2
`define PLL_DIV_MAX 62

`endif

// ==== hw/pll_pkg.sv ====
// Types shared by the lock-window block
package pll_pkg;
  typedef enum logic [1:0] {PLL_IDLE, PLL_OPEN, PLL_LATE} pll_win_state_e;
  typedef logic [1:0] pll_speed_t;
  typedef logic [2:0] pll_code_t;
  typedef logic [23:0] pll_reg_t;
endpackage : pll_pkg

// ==== hw/pll_ld_if.sv ====
// Window timer and lock counter hookup inside the block
`timescale 1ns/1ps
interface pll_ld_if;
  logic start;
  pll_pkg::pll_speed_t speed;
  pll_pkg::pll_code_t divide;
  logic digital;
  logic done;
  logic hit;
  logic miss;
  logic enable;
  pll_pkg::pll_code_t count_code;
  logic locked;
  modport tmr (input start, input speed, input divide, input digital, output done);
  modport tctl (output start, output speed, output divide, output digital, input done);
  modport cnt (input hit, input miss, input enable, input count_code, output locked);
  modport cctl (output hit, output miss, output enable, output count_code, input locked);
endinterface : pll_ld_if

// ==== hw/pll_window_timer.sv ====
// Lock-detect window timer: digital timer or fixed one-shot
`include "pll_defs.svh"
`timescale 1ns/1ps
module pll_window_timer (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  pll_ld_if.tmr ld
);
  logic running;
  logic [2:0] presc;
  logic [7:0] halves;
  logic [7:0] target;
  logic [2:0] presc_top;
  logic digital_q;
  logic [15:0] chk_cyc;
  logic [15:0] chk_exp;

  // ************************************************************
  // Timer
  // ************************************************************
  // speed sets prescaler
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      running <= 1'b0;
      presc <= 3'h0;
      halves <= 8'h00;
      target <= 8'h00;
      presc_top <= 3'h0;
      digital_q <= 1'b0;
      ld.done <= 1'b0;
    end else if (ce) begin
      ld.done <= 1'b0;
      if (ld.start) begin
        running <= 1'b1;
        presc <= 3'h0;
        halves <= 8'h00;
        digital_q <= ld.digital;
        presc_top <= {1'b0, ld.speed};
        target <= 8'h01 << ld.divide;
      end else if (running) begin
        if (!digital_q) begin
          presc <= 3'(presc + 3'h1);
          if (32'(presc) + 1 >= `PLL_ANALOG_WIN_CYC) begin
            running <= 1'b0;
            ld.done <= 1'b1;
          end
        end else if (presc == presc_top) begin
          presc <= 3'h0;
          halves <= 8'(halves + 8'h01);
          if (8'(halves + 8'h01) == target) begin
            running <= 1'b0;
            ld.done <= 1'b1;
          end
        end else begin
          presc <= 3'(presc + 3'h1);
        end
      end
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      chk_cyc <= 16'h0000;
      chk_exp <= 16'h0000;
    end else if (ce) begin
      if (ld.start) begin
        chk_cyc <= 16'h0001;
        chk_exp <= ld.digital ? 16'((16'(ld.speed) + 16'h0001) << ld.divide) : 16'(`PLL_ANALOG_WIN_CYC);
      end else if (running) begin
        chk_cyc <= 16'(chk_cyc + 16'h0001);
      end
    end
  end

  property p_window_len;
    @(posedge clk) disable iff (!reset_n) $rose(ld.done) |-> chk_cyc == chk_exp + 16'h0001;
  endproperty
  a_window_len: assert property (p_window_len) else $error("window length wrong");

  property p_speed_slowest;
    @(posedge clk) disable iff (!reset_n)
      (ce && ld.start && ld.digital && ld.speed == 2'b11 && ld.divide == 3'h0) |=> !ld.done [*4];
  endproperty
  a_speed_slowest: assert property (p_speed_slowest) else $error("slow speed closed early");
endmodule : pll_window_timer

// ==== hw/pll_lock_count.sv ====
// Consecutive in-window counter and lock flag
`include "pll_defs.svh"
`timescale 1ns/1ps
module pll_lock_count #(
  parameter int LOCK_BASE = `PLL_LOCK_BASE
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  pll_ld_if.cnt ld
);
  logic [15:0] run;
  logic [15:0] need;

  assign need = 16'(LOCK_BASE << ld.count_code);

  // ************************************************************
  // Lock declaration
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      run <= 16'h0000;
      ld.locked <= 1'b0;
    end else if (ce) begin
      if (!ld.enable) begin
        run <= 16'h0000;
        ld.locked <= 1'b0;
      end else if (ld.miss) begin
        run <= 16'h0000;
        ld.locked <= 1'b0;
      end else if (ld.hit && !ld.locked) begin
        if (16'(run + 16'h0001) >= need) begin
          ld.locked <= 1'b1;
        end
        run <= 16'(run + 16'h0001);
      end
    end
  end

  property p_miss_unlocks;
    @(posedge clk) disable iff (!reset_n) (ce && ld.miss) |=> !ld.locked;
  endproperty
  a_miss_unlocks: assert property (p_miss_unlocks) else $error("lock kept after miss");

  property p_rise_needs_run;
    @(posedge clk) disable iff (!reset_n) $rose(ld.locked) |-> $past(ld.hit) && $past(run) + 16'h0001 >= $past(need);
  endproperty
  a_rise_needs_run: assert property (p_rise_needs_run) else $error("lock rose too early");

  property p_enable_gates;
    @(posedge clk) disable iff (!reset_n) (ce && !ld.enable) |=> !ld.locked;
  endproperty
  a_enable_gates: assert property (p_enable_gates) else $error("lock while disabled");
endmodule : pll_lock_count

// ==== hw/pll_lock_ctrl.sv ====
// Lock-window detector, cycle-slip guard, pump settings and register port
//
// The plain strobed port was decided locally.
`include "pll_defs.svh"
`timescale 1ns/1ps
module pll_lock_ctrl (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic [`PLL_ADDR_W-1:0] addr,
  input wire logic [23:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [23:0] rdata,
  input wire logic ref_edge_in,
  input wire logic vco_edge_in,
  output logic lock_detect,
  output logic cycle_slip_guard,
  output logic [6:0] pump_down_gain,
  output logic [6:0] pump_up_gain,
  output logic [11:0] pump_down_ua,
  output logic [11:0] pump_up_ua,
  output logic [9:0] offset_ua,
  output logic offset_up_en,
  output logic offset_down_en,
  output logic [5:0] output_divider_select,
  output logic doubler_control
);
  pll_pkg::pll_reg_t lock_window_config;
  pll_pkg::pll_reg_t pump_gain_offset;
  pll_pkg::pll_reg_t detector_features;
  pll_pkg::pll_reg_t output_tuning;
  pll_pkg::pll_win_state_e state;
  logic [2:0] ref_sync;
  logic [2:0] vco_sync;
  logic ref_e;
  logic vco_e;
  logic first_ref;
  logic other_e;
  logic [7:0] sep;
  logic ld_en;
  logic start;
  logic hit;
  logic miss;

  pll_ld_if ld ();

  function automatic logic [7:0] csp_limit(input logic [1:0] code);
    csp_limit = 8'(`PLL_CSP_BASE << code);
  endfunction : csp_limit

  function automatic logic div_ok(input logic [5:0] v);
    div_ok = !v[0] && v >= 6'(`PLL_DIV_MIN) && v <= 6'(`PLL_DIV_MAX);
  endfunction : div_ok

  // ************************************************************
  // Register port
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      lock_window_config <= `PLL_RST_LOCK_WINDOW_CONFIG;
      pump_gain_offset <= `PLL_RST_PUMP_GAIN_OFFSET;
      detector_features <= `PLL_RST_DETECTOR_FEATURES;
      output_tuning <= `PLL_RST_OUTPUT_TUNING;
    end else if (ce && wr) begin
      case (addr)
        `PLL_OFS_LOCK_WINDOW_CONFIG: lock_window_config <= wdata;
        `PLL_OFS_PUMP_GAIN_OFFSET: pump_gain_offset <= wdata;
        `PLL_OFS_DETECTOR_FEATURES: detector_features <= wdata;
        `PLL_OFS_OUTPUT_TUNING: output_tuning <= wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdata <= 24'h000000;
    end else if (ce) begin
      rdata <= 24'h000000;
      if (rd) begin
        case (addr)
          `PLL_OFS_LOCK_WINDOW_CONFIG: rdata <= lock_window_config;
          `PLL_OFS_PUMP_GAIN_OFFSET: rdata <= pump_gain_offset;
          `PLL_OFS_DETECTOR_FEATURES: rdata <= detector_features;
          `PLL_OFS_OUTPUT_TUNING: rdata <= output_tuning;
          `PLL_OFS_LOCK_STATUS: begin
            rdata[`PLL_ST_LOCKED] <= ld.locked;
            rdata[`PLL_ST_WINDOW] <= state == pll_pkg::PLL_OPEN;
          end
          default: rdata <= 24'h000000;
        endcase
      end
    end
  end

  // ************************************************************
  // Edge inputs
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ref_sync <= 3'h0;
      vco_sync <= 3'h0;
    end else if (ce) begin
      ref_sync <= {ref_sync[1:0], ref_edge_in};
      vco_sync <= {vco_sync[1:0], vco_edge_in};
    end
  end

  assign ref_e = ref_sync[1] && !ref_sync[2];
  assign vco_e = vco_sync[1] && !vco_sync[2];
  assign other_e = first_ref ? vco_e : ref_e;
  assign ld_en = lock_window_config[`PLL_LW_ENABLE];

  // ************************************************************
  // Window state machine
  // ************************************************************
  // open on first edge
  assign start = ld_en && state == pll_pkg::PLL_IDLE && (ref_e ^ vco_e);
  assign hit = ld_en && ((state == pll_pkg::PLL_IDLE && ref_e && vco_e) || (state == pll_pkg::PLL_OPEN && other_e));
  assign miss = ld_en && state == pll_pkg::PLL_OPEN && !other_e && ld.done;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= pll_pkg::PLL_IDLE;
      first_ref <= 1'b0;
    end else if (ce) begin
      if (!ld_en) begin
        state <= pll_pkg::PLL_IDLE;
      end else begin
        case (state)
          pll_pkg::PLL_IDLE: begin
            if (start) begin
              state <= pll_pkg::PLL_OPEN;
              first_ref <= ref_e;
            end
          end
          pll_pkg::PLL_OPEN: begin
            if (other_e) begin
              state <= pll_pkg::PLL_IDLE;
            end else if (ld.done) begin
              state <= pll_pkg::PLL_LATE;
            end
          end
          pll_pkg::PLL_LATE: begin
            if (other_e) begin
              state <= pll_pkg::PLL_IDLE;
            end
          end
          default: state <= pll_pkg::PLL_IDLE;
        endcase
      end
    end
  end

  assign ld.start = start;
  assign ld.speed = lock_window_config[`PLL_LW_SPEED];
  assign ld.divide = lock_window_config[`PLL_LW_DIVIDE];
  assign ld.digital = lock_window_config[`PLL_LW_DIGITAL];
  assign ld.hit = hit;
  assign ld.miss = miss;
  assign ld.enable = ld_en;
  assign ld.count_code = lock_window_config[`PLL_LW_WINCNT];

  pll_window_timer u_timer (
    .clk(clk),
    .reset_n(reset_n),
    .ce(ce),
    .ld(ld)
  );

  pll_lock_count u_count (
    .clk(clk),
    .reset_n(reset_n),
    .ce(ce),
    .ld(ld)
  );

  // ************************************************************
  // Cycle-slip guard
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sep <= 8'h00;
    end else if (ce) begin
      if (state == pll_pkg::PLL_IDLE || other_e) begin
        sep <= 8'h00;
      end else if (sep != 8'hff) begin
        sep <= 8'(sep + 8'h01);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cycle_slip_guard <= 1'b0;
    end else if (ce) begin
      cycle_slip_guard <= !ld.locked && state != pll_pkg::PLL_IDLE && !other_e
        && sep >= csp_limit(detector_features[`PLL_DF_CSP]);
    end
  end

  // ************************************************************
  // Pump and output settings
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      lock_detect <= 1'b0;
      pump_down_gain <= 7'h00;
      pump_up_gain <= 7'h00;
      pump_down_ua <= 12'h000;
      pump_up_ua <= 12'h000;
      offset_ua <= 10'h000;
      offset_up_en <= 1'b0;
      offset_down_en <= 1'b0;
      output_divider_select <= 6'h00;
      doubler_control <= 1'b0;
    end else if (ce) begin
      lock_detect <= ld.locked;
      pump_down_gain <= pump_gain_offset[`PLL_PG_DOWN];
      pump_up_gain <= pump_gain_offset[`PLL_PG_UP];
      pump_down_ua <= 12'(pump_gain_offset[`PLL_PG_DOWN] * `PLL_GAIN_UA_PER_CODE);
      pump_up_ua <= 12'(pump_gain_offset[`PLL_PG_UP] * `PLL_GAIN_UA_PER_CODE);
      offset_ua <= 10'(pump_gain_offset[`PLL_PG_OFS_MAG] * `PLL_OFS_UA_PER_CODE);
      offset_up_en <= pump_gain_offset[`PLL_PG_OFS_UP];
      offset_down_en <= pump_gain_offset[`PLL_PG_OFS_DOWN];
      output_divider_select <= div_ok(output_tuning[`PLL_OT_DIVIDER]) ? output_tuning[`PLL_OT_DIVIDER] : 6'h01;
      doubler_control <= output_tuning[`PLL_OT_DOUBLER];
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  sequence s_single_edge;
    ce && ld_en && state == pll_pkg::PLL_IDLE && (ref_e ^ vco_e);
  endsequence

  property p_open_first;
    @(posedge clk) disable iff (!reset_n) s_single_edge |=> state == pll_pkg::PLL_OPEN;
  endproperty
  a_open_first: assert property (p_open_first) else $error("window did not open");

  property p_status_lock;
    @(posedge clk) disable iff (!reset_n)
      (ce && rd && addr == `PLL_OFS_LOCK_STATUS) |=> rdata[`PLL_ST_LOCKED] == $past(ld.locked);
  endproperty
  a_status_lock: assert property (p_status_lock) else $error("status lock bit wrong");

  property p_pump_scale;
    @(posedge clk) disable iff (!reset_n)
      ce |=> pump_up_ua == 12'($past(pump_gain_offset[`PLL_PG_UP]) * 20)
        && pump_down_gain == $past(pump_gain_offset[`PLL_PG_DOWN]);
  endproperty
  a_pump_scale: assert property (p_pump_scale) else $error("pump gain scale wrong");

  property p_offset;
    @(posedge clk) disable iff (!reset_n)
      ce |=> offset_ua == 10'($past(pump_gain_offset[20:14]) * 5) && offset_down_en == $past(pump_gain_offset[22]);
  endproperty
  a_offset: assert property (p_offset) else $error("offset setting wrong");

  property p_csp_quiet_locked;
    @(posedge clk) disable iff (!reset_n) (ce && ld.locked) |=> !cycle_slip_guard;
  endproperty
  a_csp_quiet_locked: assert property (p_csp_quiet_locked) else $error("guard active while locked");

  property p_disabled_idle;
    @(posedge clk) disable iff (!reset_n) (ce && !ld_en) |=> state == pll_pkg::PLL_IDLE && !ld.start;
  endproperty
  a_disabled_idle: assert property (p_disabled_idle) else $error("detector ran while disabled");
endmodule : pll_lock_ctrl

// ==== dv/tb_pll_lock_ctrl.sv ====
// Self-checking testbench for the lock-window and pump control block
`include "pll_defs.svh"
`timescale 1ns/1ps
module tb_pll_lock_ctrl;
  logic clk, reset_n, ce, wr, rd, ref_edge_in, vco_edge_in;
  logic [4:0] addr;
  logic [23:0] wdata, rdata;
  logic lock_detect, cycle_slip_guard, offset_up_en, offset_down_en, doubler_control;
  logic [6:0] pump_down_gain, pump_up_gain;
  logic [11:0] pump_down_ua, pump_up_ua;
  logic [9:0] offset_ua;
  logic [5:0] output_divider_select;
  int num_errors = 0;
  int check_count = 0;

  pll_lock_ctrl uut (.clk(clk), .reset_n(reset_n), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .ref_edge_in(ref_edge_in), .vco_edge_in(vco_edge_in), .lock_detect(lock_detect),
    .cycle_slip_guard(cycle_slip_guard), .pump_down_gain(pump_down_gain), .pump_up_gain(pump_up_gain),
    .pump_down_ua(pump_down_ua), .pump_up_ua(pump_up_ua), .offset_ua(offset_ua), .offset_up_en(offset_up_en),
    .offset_down_en(offset_down_en), .output_divider_select(output_divider_select),
    .doubler_control(doubler_control));

  // ************************************************************
  // Clock and watchdog
  // ************************************************************
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    stop_test();
  end

  // ************************************************************
  // Bus, edge and compare tasks
  // ************************************************************
  task automatic wr_reg(input logic [4:0] a, input logic [23:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [4:0] a, output logic [23:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg

  task automatic check_reg(input logic [4:0] a, input logic [23:0] mask, input logic [23:0] exp);
    logic [23:0] got;
    rd_reg(a, got);
    check_count++;
    if ((got & mask) !== exp) begin
      num_errors++;
      $display("[ERR] %0t reg %h read %h expected %h", $time, a, got & mask, exp);
    end
  endtask : check_reg

  task automatic check_pin(input logic [23:0] got, input logic [23:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s is %h expected %h", $time, what, got, exp);
    end
  endtask : check_pin

  // Divider levels rise together or singly, then settle low
  task automatic edge_pair(input logic r, input logic v);
    @(posedge clk);
    ref_edge_in <= r;
    vco_edge_in <= v;
    repeat (2) @(posedge clk);
    ref_edge_in <= 1'b0;
    vco_edge_in <= 1'b0;
    repeat (5) @(posedge clk);
  endtask : edge_pair

  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test

  // ************************************************************
  // Tests
  // ************************************************************
  logic [23:0] tw [4] = '{24'h000004, 24'h000005, 24'h00003e, 24'h000100};
  logic [5:0] td [4] = '{6'h04, 6'h01, 6'h3e, 6'h01};
  logic [23:0] wcfg [2] = '{24'h000c48, 24'h000008};
  logic [23:0] wopen [2] = '{24'h000001, 24'h000000};

  initial begin
    reset_n = 1'b0;
    ce = 1'b1;
    addr = '0;
    wdata = '0;
    wr = 1'b0;
    rd = 1'b0;
    ref_edge_in = 1'b0;
    vco_edge_in = 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;

    check_reg(`PLL_OFS_LOCK_WINDOW_CONFIG, 24'hffffff, `PLL_RST_LOCK_WINDOW_CONFIG);
    check_reg(`PLL_OFS_PUMP_GAIN_OFFSET, 24'hffffff, `PLL_RST_PUMP_GAIN_OFFSET);
    check_reg(`PLL_OFS_DETECTOR_FEATURES, 24'hffffff, `PLL_RST_DETECTOR_FEATURES);
    wr_reg(5'h1f, 24'h123456);
    check_reg(5'h1f, 24'hffffff, 24'h000000);
    // Clock enable low must swallow a write
    @(posedge clk);
    ce <= 1'b0;
    wr_reg(`PLL_OFS_DETECTOR_FEATURES, 24'h000180);
    ce <= 1'b1;
    check_reg(`PLL_OFS_DETECTOR_FEATURES, 24'hffffff, `PLL_RST_DETECTOR_FEATURES);
    $display("test reset and map done");

    wr_reg(`PLL_OFS_PUMP_GAIN_OFFSET, 24'h5ff232);
    repeat (2) @(posedge clk);
    #1;
    check_pin(pump_down_gain, 24'h32, "down gain");
    check_pin(pump_up_gain, 24'h64, "up gain");
    check_pin(pump_down_ua, 24'd1000, "down current");
    check_pin(pump_up_ua, 24'd2000, "up current");
    check_pin(offset_ua, 24'd635, "offset");
    check_pin({offset_up_en, offset_down_en}, 24'h1, "offset enables");
    check_reg(`PLL_OFS_PUMP_GAIN_OFFSET, 24'hffffff, 24'h5ff232);
    wr_reg(`PLL_OFS_PUMP_GAIN_OFFSET, 24'h200000);
    repeat (2) @(posedge clk);
    #1;
    check_pin({offset_up_en, offset_down_en}, 24'h2, "offset enables");
    check_pin(offset_ua, 24'd0, "offset");
    $display("test pump fields done");

    for (int i = 0; i < 4; i++) begin
      wr_reg(`PLL_OFS_OUTPUT_TUNING, tw[i]);
      repeat (2) @(posedge clk);
      #1;
      check_pin(output_divider_select, td[i], "divider");
      check_pin(doubler_control, tw[i][8], "doubler");
    end
    $display("test tuning done");

    // Timer window but global enable off
    wr_reg(`PLL_OFS_LOCK_WINDOW_CONFIG, 24'h000040);
    for (int i = 0; i < 40; i++) edge_pair(1'b1, 1'b1);
    check_pin(lock_detect, 24'h0, "lock while disabled");
    wr_reg(`PLL_OFS_LOCK_WINDOW_CONFIG, 24'h000048);
    for (int i = 0; i < 31; i++) edge_pair(1'b1, 1'b1);
    check_pin(lock_detect, 24'h0, "lock one short");
    edge_pair(1'b1, 1'b1);
    check_pin(lock_detect, 24'h1, "lock at count");
    check_reg(`PLL_OFS_LOCK_STATUS, 24'h000002, 24'h000002);
    edge_pair(1'b1, 1'b0);
    edge_pair(1'b0, 1'b1);
    check_pin(lock_detect, 24'h0, "lock after miss");
    check_reg(`PLL_OFS_LOCK_STATUS, 24'h000002, 24'h000000);
    $display("test lock detect done");

    // Long window, reference first, oscillator late
    wr_reg(`PLL_OFS_LOCK_WINDOW_CONFIG, 24'h000dc8);
    wr_reg(`PLL_OFS_DETECTOR_FEATURES, 24'h000000);
    @(posedge clk);
    ref_edge_in <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
    check_pin(cycle_slip_guard, 24'h1, "guard low threshold");
    check_reg(`PLL_OFS_LOCK_STATUS, 24'h000001, 24'h000001);
    edge_pair(1'b0, 1'b1);
    check_pin(cycle_slip_guard, 24'h0, "guard after pair");
    wr_reg(`PLL_OFS_DETECTOR_FEATURES, 24'h000180);
    check_reg(`PLL_OFS_DETECTOR_FEATURES, 24'hffffff, 24'h000180);
    @(posedge clk);
    ref_edge_in <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
    check_pin(cycle_slip_guard, 24'h0, "guard high threshold");
    edge_pair(1'b0, 1'b1);
    $display("test guard done");

    // Slowest timer window against the one-shot window
    for (int i = 0; i < 2; i++) begin
      wr_reg(`PLL_OFS_LOCK_WINDOW_CONFIG, wcfg[i]);
      @(posedge clk);
      ref_edge_in <= 1'b1;
      repeat (4) @(posedge clk);
      check_reg(`PLL_OFS_LOCK_STATUS, 24'h000001, wopen[i]);
      repeat (2) @(posedge clk);
      check_reg(`PLL_OFS_LOCK_STATUS, 24'h000001, 24'h000000);
      edge_pair(1'b0, 1'b1);
    end
    $display("test window length done");
    stop_test();
  end
endmodule : tb_pll_lock_ctrl
